// File: rtl/cbi_target.sv
// Purpose: Two-wire target port holding the clock buffer control registers
// Assumes: Link clock is slow against core_clk; both lines pass 2-FF syncs
// Notes:   Open-drain data pin split into in, out and enable

`timescale 1ns/1ps
`default_nettype none

module cbi_target
(
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe,
    input  wire logic            power_down_n,
    input  wire logic            address_select_strap,
    output cbi_pkg::cbi_ctrl_t   ctrl,
    output logic [6:0]           target_addr
);

    // ********************************************************************
    // Synchronisers
    // ********************************************************************
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] pdn_sync_r;
    logic [1:0] strap_sync_r;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       pdn_d_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_r   <= 2'b11;
            sda_sync_r   <= 2'b11;
            pdn_sync_r   <= 2'b00;
            strap_sync_r <= 2'b11;
            scl_d_r      <= 1'b1;
            sda_d_r      <= 1'b1;
            pdn_d_r      <= 1'b0;
        end
        else
        begin
            scl_sync_r   <= {scl_sync_r[0], scl_i};
            sda_sync_r   <= {sda_sync_r[0], sda_i};
            pdn_sync_r   <= {pdn_sync_r[0], power_down_n};
            strap_sync_r <= {strap_sync_r[0], address_select_strap};
            scl_d_r      <= scl_sync_r[1];
            sda_d_r      <= sda_sync_r[1];
            pdn_d_r      <= pdn_sync_r[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic pdn_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_s    = scl_sync_r[1];
    assign sda_s    = sda_sync_r[1];
    assign pdn_s    = pdn_sync_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    // Start/stop only while clock stays high, so data moves are not mistaken
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ********************************************************************
    // Address strap
    // ********************************************************************
    logic seen_release_r;
    logic strap_r;

    // Only the very first release counts; later power cycles keep the address
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            seen_release_r <= 1'b0;
            strap_r        <= 1'b1;
        end
        else if (pdn_s && !pdn_d_r && !seen_release_r)
        begin
            seen_release_r <= 1'b1;
            strap_r        <= strap_sync_r[1];
        end
    end

    assign target_addr = strap_r ? cbi_pkg::ADDR_STRAP_HI
                                 : cbi_pkg::ADDR_STRAP_LO;

    // ********************************************************************
    // Register file
    // ********************************************************************
    logic [7:0]             regs_r [cbi_pkg::NUM_REGS];
    logic                   wr_stb_r;
    logic [cbi_pkg::IDX_W-1:0] wr_idx_r;
    logic [7:0]             wr_dat_r;

    genvar gi;
    generate
        for (gi = 0; gi < cbi_pkg::NUM_REGS; gi++)
        begin : g_reg
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    regs_r[gi] <= cbi_pkg::REG_DEFAULT[gi];
                else if (wr_stb_r && wr_idx_r == cbi_pkg::IDX_W'(gi))
                    regs_r[gi] <= (wr_dat_r & cbi_pkg::REG_WMASK[gi])
                                | (regs_r[gi] & ~cbi_pkg::REG_WMASK[gi]);
            end
        end
    endgenerate

    function automatic logic [7:0] rd_reg(input logic [cbi_pkg::IDX_W-1:0] idx);
        logic [7:0] v;
        v = cbi_pkg::UNMAPPED_RD;
        for (int k = 0; k < cbi_pkg::NUM_REGS; k++)
            if (idx == cbi_pkg::IDX_W'(k))
                v = regs_r[k];
        return v;
    endfunction

    // ********************************************************************
    // Control outputs
    // ********************************************************************
    // Clock enables forced off while powered down; slew, amp and registers untouched
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctrl <= '0;
        else
        begin
            ctrl.clk_oe    <= pdn_s ? {regs_r[cbi_pkg::IDX_OE_HI][7:4],
                                       regs_r[cbi_pkg::IDX_OE_LO]}
                                    : 12'h000;
            ctrl.slew_fast <= {regs_r[cbi_pkg::IDX_SLEW_HI][7:4],
                               regs_r[cbi_pkg::IDX_SLEW_LO]};
            ctrl.amp       <= regs_r[cbi_pkg::IDX_SLEW_HI][3:0];
        end
    end

    // ********************************************************************
    // Protocol engine
    // ********************************************************************
    cbi_pkg::cbi_phase_t    phase_r;
    logic [3:0]             bit_r;
    logic [7:0]             rx_r;
    logic [7:0]             tx_r;
    logic                   block_r;
    logic                   cnt_bad_r;
    logic                   send_cnt_r;
    logic                   mack_r;
    logic [7:0]             left_r;
    logic [cbi_pkg::IDX_W-1:0] idx_r;
    logic [7:0]             rd_byte;

    assign sda_o   = 1'b0;
    assign rd_byte = rd_reg(idx_r);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_r    <= cbi_pkg::PH_IDLE;
            bit_r      <= 4'h0;
            rx_r       <= 8'h00;
            tx_r       <= 8'h00;
            block_r    <= 1'b0;
            cnt_bad_r  <= 1'b0;
            send_cnt_r <= 1'b0;
            mack_r     <= 1'b0;
            left_r     <= 8'h00;
            idx_r      <= '0;
            sda_oe     <= 1'b0;
            wr_stb_r   <= 1'b0;
            wr_idx_r   <= '0;
            wr_dat_r   <= 8'h00;
        end
        else
        begin
            wr_stb_r <= 1'b0;
            if (!pdn_s)
            begin
                phase_r <= cbi_pkg::PH_IDLE;
                sda_oe  <= 1'b0;
            end
            else if (start_ev)
            begin
                // Repeated start keeps the index set by the command byte
                // Fall that closes the start ends a dummy slot, not a bit
                phase_r <= cbi_pkg::PH_ADDR;
                bit_r   <= cbi_pkg::ACK_SLOT;
                sda_oe  <= 1'b0;
            end
            else if (stop_ev)
            begin
                phase_r <= cbi_pkg::PH_IDLE;
                sda_oe  <= 1'b0;
            end
            else if (phase_r != cbi_pkg::PH_IDLE && phase_r != cbi_pkg::PH_IGNORE)
            begin
                if (scl_rise)
                begin
                    if (bit_r < cbi_pkg::ACK_SLOT)
                        rx_r <= {rx_r[6:0], sda_s};
                    else if (phase_r == cbi_pkg::PH_TX)
                        mack_r <= ~sda_s;
                end
                else if (scl_fall)
                begin
                    if (phase_r == cbi_pkg::PH_TX)
                    begin
                        if (bit_r < cbi_pkg::LAST_BIT)
                        begin
                            tx_r   <= {tx_r[6:0], 1'b0};
                            sda_oe <= ~tx_r[6];
                            bit_r  <= bit_r + 4'h1;
                        end
                        else if (bit_r == cbi_pkg::LAST_BIT)
                        begin
                            sda_oe <= 1'b0;
                            bit_r  <= cbi_pkg::ACK_SLOT;
                        end
                        else if (sda_oe)
                        begin
                            // Our read-address ack ends: first byte goes out
                            if (send_cnt_r)
                            begin
                                tx_r   <= cbi_pkg::BLK_CNT_MAX;
                                sda_oe <= ~cbi_pkg::BLK_CNT_MAX[7];
                            end
                            else
                            begin
                                tx_r   <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                                idx_r  <= idx_r + 1'b1;
                            end
                            send_cnt_r <= 1'b0;
                            bit_r      <= 4'h0;
                        end
                        else if (mack_r)
                        begin
                            // Controller asked for more: next register
                            tx_r       <= rd_byte;
                            sda_oe     <= ~rd_byte[7];
                            idx_r      <= idx_r + 1'b1;
                            bit_r      <= 4'h0;
                        end
                        else
                        begin
                            phase_r <= cbi_pkg::PH_IGNORE;
                            sda_oe  <= 1'b0;
                        end
                    end
                    else if (bit_r < cbi_pkg::LAST_BIT)
                        bit_r <= bit_r + 4'h1;
                    else if (bit_r == cbi_pkg::LAST_BIT)
                    begin
                        bit_r <= cbi_pkg::ACK_SLOT;
                        case (phase_r)
                            cbi_pkg::PH_ADDR:
                            begin
                                if (rx_r[7:1] == target_addr)
                                begin
                                    sda_oe <= 1'b1;
                                    if (rx_r[0])
                                    begin
                                        phase_r    <= cbi_pkg::PH_TX;
                                        send_cnt_r <= block_r;
                                    end
                                    else
                                        phase_r <= cbi_pkg::PH_CMD;
                                end
                                else
                                    phase_r <= cbi_pkg::PH_IGNORE;
                            end
                            cbi_pkg::PH_CMD:
                            begin
                                sda_oe  <= 1'b1;
                                block_r <= ~rx_r[7];
                                idx_r   <= rx_r[6:0];
                                left_r  <= 8'h01;
                                cnt_bad_r <= 1'b0;
                                phase_r <= rx_r[7] ? cbi_pkg::PH_WDATA
                                                   : cbi_pkg::PH_COUNT;
                            end
                            cbi_pkg::PH_COUNT:
                            begin
                                sda_oe    <= 1'b1;
                                left_r    <= rx_r;
                                cnt_bad_r <= (rx_r < cbi_pkg::BLK_CNT_MIN)
                                           || (rx_r > cbi_pkg::BLK_CNT_MAX);
                                phase_r   <= cbi_pkg::PH_WDATA;
                            end
                            cbi_pkg::PH_WDATA:
                            begin
                                sda_oe <= 1'b1;
                                if (left_r != 8'h00 && !cnt_bad_r)
                                begin
                                    wr_stb_r <= 1'b1;
                                    wr_idx_r <= idx_r;
                                    wr_dat_r <= rx_r;
                                    idx_r    <= idx_r + 1'b1;
                                    left_r   <= left_r - 8'h01;
                                end
                            end
                            default:
                                phase_r <= cbi_pkg::PH_IGNORE;
                        endcase
                    end
                    else
                    begin
                        // End of our acknowledge slot
                        bit_r  <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // cbi_target

`default_nettype wire

// File: rtl/cbi_pkg.sv
// Purpose: Shared constants and types for the clock buffer two-wire target port
// Assumes: 100 MHz core clock; link clock sampled as ordinary input
// Notes:   Register defaults and write masks live here, one entry per index
package cbi_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int NUM_REGS = 7;
    localparam int IDX_W    = 7;

    // Identity byte; value is arbitrary and neutral
    localparam logic [7:0] ID_BYTE = 8'h5A;

    localparam logic [7:0] REG_DEFAULT [NUM_REGS] = '{
        8'hFF, 8'hF0, 8'h00, 8'hFF, 8'hF8, ID_BYTE, 8'h00
    };
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
        8'hFF, 8'hF0, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00
    };

    localparam int IDX_OE_LO   = 0;
    localparam int IDX_OE_HI   = 1;
    localparam int IDX_SLEW_LO = 3;
    localparam int IDX_SLEW_HI = 4;

    // ********************************************************************
    // Protocol constants
    // ********************************************************************
    localparam logic [6:0] ADDR_STRAP_LO = 7'h69;   // 1101001
    localparam logic [6:0] ADDR_STRAP_HI = 7'h6A;   // 1101010
    localparam logic [7:0] BLK_CNT_MIN   = 8'h01;
    localparam logic [7:0] BLK_CNT_MAX   = 8'h06;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [3:0] LAST_BIT      = 4'h7;
    localparam logic [7:0] UNMAPPED_RD   = 8'h00;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_ADDR   = 3'b001,
        PH_CMD    = 3'b010,
        PH_COUNT  = 3'b011,
        PH_WDATA  = 3'b100,
        PH_TX     = 3'b101,
        PH_IGNORE = 3'b110
    } cbi_phase_t;

    typedef struct packed {
        logic [11:0] clk_oe;
        logic [11:0] slew_fast;
        logic [3:0]  amp;
    } cbi_ctrl_t;

endpackage

// File: testbench/cbi_target_properties.sv
// Purpose: Port assertions for the two-wire target port
// Assumes: One clock domain, rst active high
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module cbi_target_properties
(
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               scl_i,
    input wire logic               sda_i,
    input wire logic               sda_o,
    input wire logic               sda_oe,
    input wire logic               power_down_n,
    input wire logic               address_select_strap,
    input wire cbi_pkg::cbi_ctrl_t ctrl,
    input wire logic [6:0]         target_addr
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    pd_gate_a: assert property (!power_down_n [*4] |-> ctrl.clk_oe == 12'h000)
        else $error("outputs enabled in power down");
    pd_quiet_a: assert property (!power_down_n [*4] |-> !sda_oe)
        else $error("data line pulled in power down");
    addr_legal_a: assert property (target_addr inside {7'h69, 7'h6A})
        else $error("answering address not a strap value");
    addr_locked_a: assert property (power_down_n [*8] |=> $stable(target_addr))
        else $error("answering address moved");
    ctrl_quiet_a: assert property (scl_i [*8] |=> $stable({ctrl.slew_fast, ctrl.amp}))
        else $error("control changed with bus idle");
    drive_phase_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line changed while clock high");
    drive_bound_a: assert property ($rose(sda_oe) |-> ##[1:160] !sda_oe)
        else $error("data line held too long");
endmodule // cbi_target_properties

bind cbi_target cbi_target_properties cbi_target_properties_inst
(
    .core_clk(core_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .power_down_n(power_down_n),
    .address_select_strap(address_select_strap),
    .ctrl(ctrl),
    .target_addr(target_addr)
);
`default_nettype wire

// File: testbench/cbi_host.sv
// Purpose: Behavioural two-wire bus controller
// Assumes: 80 ns bit period, pulled-up data line
// Notes:   Calls begin on a core clock falling edge
`timescale 1ns/1ps
`default_nettype none
module cbi_host
(
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    // ********
    // Bus cycles
    // ********
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Long low phase lets the target answer past its syncs
    task automatic bit_io(input logic b, output logic r);
        #10 sda_low = !b;
        #40 scl = 1'b1;
        #20 r = sda;
        #10 scl = 1'b0;
    endtask
    task automatic start();
        #10 sda_low = 1'b0;
        #40 scl = 1'b1;
        #20 sda_low = 1'b1;
        #10 scl = 1'b0;
    endtask
    task automatic stop();
        #10 sda_low = 1'b1;
        #40 scl = 1'b1;
        #20 sda_low = 1'b0;
        #10;
    endtask
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic byte_rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // cbi_host
`default_nettype wire

// File: testbench/clock_buffer_i2c_target_port_bench.sv
// Purpose: Self-checking bench for the two-wire target port
// Assumes: Strap low at first power-down release
// Notes:   Bus traffic comes from the cbi_host model
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_i2c_target_port_bench;
    localparam logic [6:0]  ADDR = 7'h69;
    localparam logic [27:0] CTRL_B = {12'hF3C, 12'h5A5, 4'hF};
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               power_down_n = 1'b0;
    logic               address_select_strap = 1'b0;
    logic               scl;
    logic               sda_low;
    logic               sda_o;
    logic               sda_oe;
    wire                sda_line = !(sda_low || sda_oe);
    cbi_pkg::cbi_ctrl_t ctrl;
    logic [6:0]         target_addr;
    int                 n_errors = 0;
    int                 total_checks = 0;

    always #5 core_clk = ~core_clk;

    cbi_target cbi_target_inst (.core_clk(core_clk), .rst(rst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .power_down_n(power_down_n),
        .address_select_strap(address_select_strap), .ctrl(ctrl),
        .target_addr(target_addr));
    cbi_host cbi_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda_line));

    // ********
    // Checks and frames
    // ********
    task automatic chk_val(input string what, input logic [27:0] exp, input logic [27:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic write_frame(input logic [6:0] a, input logic [7:0] q[$], input logic ok);
        logic ack;
        cbi_host_inst.start();
        cbi_host_inst.byte_wr({a, 1'b0}, ack);
        chk_bit("address ack", ok, ack);
        foreach (q[i])
        begin
            cbi_host_inst.byte_wr(q[i], ack);
            chk_bit("write ack", ok, ack);
        end
        cbi_host_inst.stop();
        repeat (4) @(negedge core_clk);
    endtask
    task automatic read_frame(input logic [7:0] cmd, input logic [7:0] exp[$]);
        logic       ack;
        logic [7:0] b;
        cbi_host_inst.start();
        cbi_host_inst.byte_wr({ADDR, 1'b0}, ack);
        chk_bit("write address ack", 1'b1, ack);
        cbi_host_inst.byte_wr(cmd, ack);
        chk_bit("command ack", 1'b1, ack);
        cbi_host_inst.start();
        cbi_host_inst.byte_wr({ADDR, 1'b1}, ack);
        chk_bit("read address ack", 1'b1, ack);
        foreach (exp[i])
        begin
            cbi_host_inst.byte_rd(i == exp.size() - 1, b);
            chk_val("read byte", 28'(exp[i]), 28'(b));
        end
        cbi_host_inst.stop();
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_defaults();
        chk_val("ctrl", {12'hFFF, 12'hFFF, 4'h8}, ctrl);
        chk_val("address", 28'(ADDR), 28'(target_addr));
        $display("t_defaults done");
    endtask
    task automatic t_byte();
        write_frame(ADDR, '{8'h80, 8'h3C}, 1'b1);
        write_frame(ADDR, '{8'h85, 8'h00, 8'h00}, 1'b1);
        chk_val("ctrl", {12'hF3C, 12'hFFF, 4'h8}, ctrl);
        read_frame(8'h80, '{8'h3C});
        read_frame(8'h85, '{cbi_pkg::ID_BYTE});
        $display("t_byte done");
    endtask
    task automatic t_block();
        write_frame(ADDR, '{8'h03, 8'h02, 8'hA5, 8'h5F}, 1'b1);
        chk_val("ctrl", CTRL_B, ctrl);
        read_frame(8'h00, '{8'h06, 8'h3C, 8'hF0, 8'h00, 8'hA5, 8'h5F, cbi_pkg::ID_BYTE});
        $display("t_block done");
    endtask
    task automatic t_refused();
        write_frame(ADDR, '{8'h00, 8'h07, 8'h11}, 1'b1);
        write_frame(ADDR, '{8'h00, 8'h00, 8'h22}, 1'b1);
        write_frame(7'h6A, '{8'h80, 8'h00}, 1'b0);
        chk_val("ctrl", CTRL_B, ctrl);
        $display("t_refused done");
    endtask
    task automatic t_power();
        power_down_n = 1'b0;
        repeat (8) @(negedge core_clk);
        chk_val("ctrl", {12'h000, 12'h5A5, 4'hF}, ctrl);
        write_frame(ADDR, '{8'h80, 8'h00}, 1'b0);
        power_down_n = 1'b1;
        repeat (8) @(negedge core_clk);
        chk_val("ctrl", CTRL_B, ctrl);
        chk_val("address", 28'(ADDR), 28'(target_addr));
        $display("t_power done");
    endtask

    initial
    begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        power_down_n = 1'b1;
        repeat (10) @(negedge core_clk);
        // Strap moves after the latch; address must not follow
        address_select_strap = 1'b1;
        t_defaults();
        t_byte();
        t_block();
        t_refused();
        t_power();
        wrap_up();
    end
    initial
    begin
        #400us;
        n_errors++;
        $display("[FAIL] watchdog expired");
        wrap_up();
    end
endmodule // clock_buffer_i2c_target_port_bench
`default_nettype wire
